// ===== hw/mtat_map.svh
// constants for the motor tick and converter trigger block
// assumes one 200 MHz core clock that also serves as peripheral_clock_b
//
// Behaviour
// - speed tick every 0.5 ms
// - relay tick every 1 ms
// - every converter result is 12 bits
// - calibrate after start-up, then allow scans
// - calibration wait allows several milliseconds
// - current sampling at carrier troughs
// - trigger on down-count compare match at zero
// - bus voltage on first_converter_unit channel 6
// - U-phase current on channel 4
// - V-phase current on channel 2
// - W-phase current on channel 0
// - carrier counts symmetric triangle, one trough per period
`ifndef MTAT_MAP_SVH
`define MTAT_MAP_SVH

// core clock rate, cycles per microsecond
`define MTAT_CLK_MHZ         200
// interval periods in microseconds
`define MTAT_SPEED_PERIOD_US 500
`define MTAT_RELAY_PERIOD_US 1000
// carrier period in microseconds
`define MTAT_CARRIER_PER_US  125
// calibration wait limit in microseconds (several ms expected)
`define MTAT_CAL_LIMIT_US    10000

// derived cycle counts
`define MTAT_SPEED_CYC  (`MTAT_SPEED_PERIOD_US * `MTAT_CLK_MHZ)
`define MTAT_RELAY_CYC  (`MTAT_RELAY_PERIOD_US * `MTAT_CLK_MHZ)
`define MTAT_CARRIER_HALF (`MTAT_CARRIER_PER_US * `MTAT_CLK_MHZ / 2)
`define MTAT_CAL_CYC    (`MTAT_CAL_LIMIT_US * `MTAT_CLK_MHZ)

// converter result width and channel numbers
`define MTAT_RES_W      12
`define MTAT_CH_W       4
`define MTAT_CH_W_PH    4'h0
`define MTAT_CH_V_PH    4'h2
`define MTAT_CH_U_PH    4'h4
`define MTAT_CH_BUS     4'h6
// number of channels in one scan
`define MTAT_SCAN_LEN   4

`endif

// ===== hw/mtat_pkg.sv
// types shared by the motor tick and converter trigger block
// assumes mtat_map.svh supplies the numbers
package mtat_pkg;

    // converter sequencer states, one-hot
    typedef enum logic [4:0] {
        MTAT_CAL_REQ  = 5'h01,   // ask converter to calibrate
        MTAT_CAL_WAIT = 5'h02,   // wait for calibration end
        MTAT_IDLE     = 5'h04,   // ready, waiting for a trough
        MTAT_CONV     = 5'h08,   // request held, waiting for done
        MTAT_RELEASE  = 5'h10    // request dropped, waiting done low
    } mtat_state_t;

    // position within one scan
    typedef logic [1:0] mtat_slot_t;

endpackage

// ===== hw/mtat_interval_timer.sv
// periodic 32-bit down-counter with a one-cycle tick on underflow
// assumes a free-running core clock and synchronous active-low reset
`include "mtat_map.svh"
module mtat_interval_timer #(
    parameter int unsigned PERIOD_CYC = `MTAT_SPEED_CYC
) (
    input  wire logic core_clk,
    input  wire logic rst_b,
    input  wire logic run,
    output logic      tick
);
    // counter must fit in 32 bits and need at least two states
    if (PERIOD_CYC < 2)
        $error("mtat_interval_timer: PERIOD_CYC below 2");

    localparam logic [31:0] RELOAD = 32'(PERIOD_CYC - 1);

    logic [31:0] cnt_r;      // current count
    logic [31:0] cnt_nxt;
    logic        tick_r;     // registered underflow pulse
    logic        tick_nxt;

    // count down, reload on underflow; no waveform pin driven
    always_comb
    begin
        cnt_nxt  = cnt_r;
        tick_nxt = 1'b0;
        if (run)
        begin
            if (cnt_r == 32'h0)
            begin
                cnt_nxt  = RELOAD;
                tick_nxt = 1'b1;
            end
            else
            begin
                cnt_nxt = cnt_r - 32'h1;
            end
        end
    end

    // register stage
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            cnt_r  <= RELOAD;
            tick_r <= 1'b0;
        end
        else
        begin
            cnt_r  <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick = tick_r;
endmodule // mtat_interval_timer

// ===== hw/mtat_carrier.sv
// symmetric triangle carrier counter with trough compare match
// assumes the same core clock and reset as the rest of the block
`include "mtat_map.svh"
module mtat_carrier #(
    parameter int unsigned HALF_CYC = `MTAT_CARRIER_HALF
) (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    output logic             trough,
    output logic             counting_down
);
    // peak must fit the 16-bit counter
    if (HALF_CYC < 2 || HALF_CYC > 65535)
        $error("mtat_carrier: HALF_CYC out of range");

    localparam logic [15:0] PEAK = 16'(HALF_CYC);

    logic [15:0] cnt_r;      // carrier value
    logic [15:0] cnt_nxt;
    logic        down_r;     // direction, high while counting down
    logic        down_nxt;
    logic        trough_r;   // compare match at zero on the way down
    logic        trough_nxt;

    // up to peak, down to zero, then turn round
    always_comb
    begin
        cnt_nxt    = cnt_r;
        down_nxt   = down_r;
        trough_nxt = 1'b0;
        if (down_r)
        begin
            cnt_nxt = cnt_r - 16'h1;
            if (cnt_r == 16'h1)
            begin
                down_nxt   = 1'b0;
                trough_nxt = 1'b1;
            end
        end
        else
        begin
            cnt_nxt = cnt_r + 16'h1;
            if (cnt_r == PEAK - 16'h1)
                down_nxt = 1'b1;
        end
    end

    // register stage; start at zero counting up so the first trough is a full period
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            cnt_r    <= 16'h0;
            down_r   <= 1'b0;
            trough_r <= 1'b0;
        end
        else
        begin
            cnt_r    <= cnt_nxt;
            down_r   <= down_nxt;
            trough_r <= trough_nxt;
        end
    end

    assign trough        = trough_r;
    assign counting_down = down_r;
endmodule // mtat_carrier

// ===== hw/mtat_top.sv
// motor tick and converter trigger: two interval ticks, carrier, and
// a sequencer that calibrates first_converter_unit and then runs one
// four-channel scan per carrier trough
// assumes the converter answers each request with a four-phase
// handshake (done rises, request drops, done falls) and holds its
// result stable while done is high; converter inputs are asynchronous
// limitation: a trough that lands during a scan is dropped, not queued
// both timers run from reset; no enable, no waveform pin
// results stay until the next scan overwrites them
`include "mtat_map.svh"
module mtat_top #(
    parameter int unsigned SPEED_CYC   = `MTAT_SPEED_CYC,
    parameter int unsigned RELAY_CYC   = `MTAT_RELAY_CYC,
    parameter int unsigned CARRIER_HALF = `MTAT_CARRIER_HALF,
    parameter int unsigned CAL_CYC     = `MTAT_CAL_CYC
) (
    input  wire logic                   core_clk,
    input  wire logic                   rst_b,
    input  wire logic                   cal_done_in,
    input  wire logic                   conv_done_in,
    input  wire logic [`MTAT_RES_W-1:0] conv_data_in,
    output logic                        speed_tick,
    output logic                        relay_tick,
    output logic                        cal_req,
    output logic                        cal_timeout,
    output logic                        scan_ready,
    output logic                        conv_req,
    output logic [`MTAT_CH_W-1:0]       conv_chan,
    output logic                        scan_done,
    output logic                        trig_missed,
    output logic [`MTAT_RES_W-1:0]      bus_volt,
    output logic [`MTAT_RES_W-1:0]      cur_u,
    output logic [`MTAT_RES_W-1:0]      cur_v,
    output logic [`MTAT_RES_W-1:0]      cur_w
);
    // calibration limit counter is 32 bits wide
    // a limit below two counts leaves no wait at all
    if (CAL_CYC < 2)
        $error("mtat_top: CAL_CYC below 2");

    // last count of the calibration wait, last slot of a scan
    localparam logic [31:0] CAL_LAST = 32'(CAL_CYC - 1);
    localparam logic [1:0]  SLOT_LAST = 2'(`MTAT_SCAN_LEN - 1);

    // interval ticks straight from the timer flops
    // run tied high: both timers count from reset release
    mtat_interval_timer #(
        .PERIOD_CYC (SPEED_CYC)
    ) u_speed_tick_timer (
        .core_clk   (core_clk),
        .rst_b      (rst_b),
        .run        (1'b1),
        .tick       (speed_tick)
    );

    // relay pacing, same counter at twice the speed interval
    mtat_interval_timer #(
        .PERIOD_CYC (RELAY_CYC)
    ) u_relay_tick_timer (
        .core_clk   (core_clk),
        .rst_b      (rst_b),
        .run        (1'b1),
        .tick       (relay_tick)
    );

    // one trough pulse per carrier period paces every scan
    logic trough;                       // carrier compare match pulse

    // count direction is not needed outside the carrier
    mtat_carrier #(
        .HALF_CYC      (CARRIER_HALF)
    ) u_carrier (
        .core_clk      (core_clk),
        .rst_b         (rst_b),
        .trough        (trough),
        .counting_down ()
    );

    // synchronisers for converter inputs; all are asynchronous
    // to core_clk, so no logic looks before the second stage
    logic                   cal_s1_r;   // first stage, read by s2 only
    logic                   cal_s2_r;
    logic                   done_s1_r;  // first stage, read by s2 only
    logic                   done_s2_r;
    // the word is qualified by done, so bit skew is harmless
    logic [`MTAT_RES_W-1:0] data_s1_r;  // first stage, read by s2 only
    logic [`MTAT_RES_W-1:0] data_s2_r;

    // two flops before any logic looks at a converter signal
    // reset clears the stages so a stale done is never taken
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            cal_s1_r  <= 1'b0;
            cal_s2_r  <= 1'b0;
            done_s1_r <= 1'b0;
            done_s2_r <= 1'b0;
            data_s1_r <= '0;
            data_s2_r <= '0;
        end
        else
        begin
            cal_s1_r  <= cal_done_in;
            cal_s2_r  <= cal_s1_r;
            done_s1_r <= conv_done_in;
            done_s2_r <= done_s1_r;
            data_s1_r <= conv_data_in;
            data_s2_r <= data_s1_r;
        end
    end

    // sequencer state; the 32-bit wait counter covers about 21 s at 200 MHz,
    // far more than the few ms a calibration is expected to take
    mtat_pkg::mtat_state_t  st_r;        // current state
    mtat_pkg::mtat_state_t  st_nxt;
    mtat_pkg::mtat_slot_t   slot_r;      // channel position in the scan
    mtat_pkg::mtat_slot_t   slot_nxt;
    logic [31:0]            calcnt_r;    // calibration wait counter
    logic [31:0]            calcnt_nxt;
    logic                   calto_r;     // calibration took too long
    logic                   calto_nxt;
    logic                   done_pl_r;   // scan finished pulse
    logic                   done_pl_nxt;
    logic                   miss_r;      // trough came while busy
    logic                   miss_nxt;
    logic                   cap_pend_r;  // result word due next cycle
    logic                   cap_pend_nxt;
    logic [`MTAT_RES_W-1:0] res_r [`MTAT_SCAN_LEN]; // results per slot
    logic [`MTAT_RES_W-1:0] res_nxt [`MTAT_SCAN_LEN];
    logic [`MTAT_CH_W-1:0]  chan_nxt;    // channel for the current slot
    logic [`MTAT_CH_W-1:0]  chan_r;

    // slot to channel: W, V, U, then bus voltage; decoded from the
    // next slot so the channel register changes on the same edge as
    // the request rises, never a cycle behind it
    always_comb
    begin
        unique case (slot_nxt)
            2'h0:    chan_nxt = `MTAT_CH_W_PH;
            2'h1:    chan_nxt = `MTAT_CH_V_PH;
            2'h2:    chan_nxt = `MTAT_CH_U_PH;
            default: chan_nxt = `MTAT_CH_BUS;
        endcase
    end

    // next-state logic for the sequencer
    always_comb
    begin
        st_nxt      = st_r;
        slot_nxt    = slot_r;
        calcnt_nxt  = calcnt_r;
        calto_nxt   = calto_r;
        done_pl_nxt = 1'b0;
        miss_nxt    = 1'b0;
        cap_pend_nxt = 1'b0;
        res_nxt     = res_r;
        unique case (st_r)
            mtat_pkg::MTAT_CAL_REQ:
            begin
                // calibration is always the first thing after reset
                // the counter restarts with every calibration request
                calcnt_nxt = 32'h0;
                st_nxt     = mtat_pkg::MTAT_CAL_WAIT;
            end
            mtat_pkg::MTAT_CAL_WAIT:
            begin
                // no scan until the converter reports the end; the
                // limit only flags a slow converter, it never skips
                // the wait, since early results are worthless
                // troughs in this state are ignored
                if (cal_s2_r)
                    st_nxt = mtat_pkg::MTAT_IDLE;
                else if (calcnt_r == CAL_LAST)
                    calto_nxt = 1'b1;
                else
                    calcnt_nxt = calcnt_r + 32'h1;
            end
            mtat_pkg::MTAT_IDLE:
            begin
                // a trough starts exactly one single-pass scan
                if (trough)
                begin
                    // every scan starts again at the first slot
                    slot_nxt = 2'h0;
                    st_nxt   = mtat_pkg::MTAT_CONV;
                end
            end
            mtat_pkg::MTAT_CONV:
            begin
                // once done is seen, take the word a cycle later: by
                // then it has stood still through every word stage
                if (done_s2_r)
                begin
                    cap_pend_nxt = 1'b1;
                    st_nxt       = mtat_pkg::MTAT_RELEASE;
                end
                // a trough now is dropped and reported, never queued
                miss_nxt = trough;
            end
            mtat_pkg::MTAT_RELEASE:
            begin
                // take the word held since done was seen
                if (cap_pend_r)
                    res_nxt[slot_r] = data_s2_r;
                // wait for done to fall before the next channel
                if (!done_s2_r)
                begin
                    if (slot_r == SLOT_LAST)
                    begin
                        done_pl_nxt = 1'b1;
                        st_nxt      = mtat_pkg::MTAT_IDLE;
                    end
                    else
                    begin
                        slot_nxt = slot_r + 2'h1;
                        st_nxt   = mtat_pkg::MTAT_CONV;
                    end
                end
                // same drop rule while the channel is released
                miss_nxt = trough;
            end
            default:
            begin
                // illegal code: restart with calibration
                // since results can no longer be trusted
                st_nxt = mtat_pkg::MTAT_CAL_REQ;
            end
        endcase
    end

    // sequencer registers; chan_r resets to the first scan channel
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            st_r      <= mtat_pkg::MTAT_CAL_REQ;
            slot_r    <= 2'h0;
            calcnt_r  <= 32'h0;
            calto_r   <= 1'b0;
            done_pl_r <= 1'b0;
            miss_r    <= 1'b0;
            cap_pend_r <= 1'b0;
            chan_r    <= `MTAT_CH_W_PH;
            // results clear so no stale value outlives a reset
            for (int i = 0; i < `MTAT_SCAN_LEN; i++)
                res_r[i] <= '0;
        end
        else
        begin
            st_r      <= st_nxt;
            slot_r    <= slot_nxt;
            calcnt_r  <= calcnt_nxt;
            calto_r   <= calto_nxt;
            done_pl_r <= done_pl_nxt;
            miss_r    <= miss_nxt;
            cap_pend_r <= cap_pend_nxt;
            chan_r    <= chan_nxt;
            res_r     <= res_nxt;
        end
    end

    // registered handshake and status outputs; they follow st_nxt so
    // each changes on the same edge as the state, not a cycle after
    logic cal_req_r;    // calibration requested, not yet ended
    logic ready_r;      // calibration complete
    logic conv_req_r;   // conversion request level

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            cal_req_r  <= 1'b0;
            ready_r    <= 1'b0;
            conv_req_r <= 1'b0;
        end
        else
        begin
            cal_req_r  <= (st_nxt == mtat_pkg::MTAT_CAL_WAIT);
            // ready holds through every scan state; only reset or an illegal state code drops it
            ready_r    <= (st_nxt == mtat_pkg::MTAT_IDLE)
                       || (st_nxt == mtat_pkg::MTAT_CONV)
                       || (st_nxt == mtat_pkg::MTAT_RELEASE);
            // request drops on the edge the state leaves CONV
            conv_req_r <= (st_nxt == mtat_pkg::MTAT_CONV);
        end
    end

    // channel and request rise on the same edge, so the channel is
    // valid for the whole of each request
    assign cal_req     = cal_req_r;
    assign cal_timeout = calto_r;
    assign scan_ready  = ready_r;
    assign conv_req    = conv_req_r;
    assign conv_chan   = chan_r;
    assign scan_done   = done_pl_r;
    assign trig_missed = miss_r;
    // result slots in scan order: W, V, U, bus voltage
    assign cur_w       = res_r[0];
    assign cur_v       = res_r[1];
    assign cur_u       = res_r[2];
    assign bus_volt    = res_r[3];
endmodule // mtat_top

// ===== tb/mtat_monitor.sv
// checker for mtat_top: tick periods, calibration gate, scan order
// assumes a bind onto mtat_top, one clock, sync active-low reset
`include "mtat_map.svh"
module mtat_monitor #(
    parameter int unsigned SPEED_CYC    = 50,
    parameter int unsigned RELAY_CYC    = 100,
    parameter int unsigned CARRIER_HALF = 40
) (
    input wire logic                  core_clk,
    input wire logic                  rst_b,
    input wire logic                  cal_done_in,
    input wire logic                  speed_tick,
    input wire logic                  relay_tick,
    input wire logic                  cal_req,
    input wire logic                  cal_timeout,
    input wire logic                  scan_ready,
    input wire logic                  conv_req,
    input wire logic [`MTAT_CH_W-1:0] conv_chan,
    input wire logic                  scan_done
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [31:0] spd_r, spd_nxt;  // cycles since speed tick
    logic [31:0] rly_r, rly_nxt;  // cycles since relay tick
    logic [31:0] trg_r, trg_nxt;  // cycles since scan start
    logic [2:0]  seen_r, seen_nxt; // first event seen flags
    logic [3:0]  last_r, last_nxt; // channel of latest request
    logic        req_d_r, req_d_nxt; // request one cycle back
    logic        rise;             // request rising now

    // next history; counters gated by seen, so no reset needed
    always_comb
    begin
        rise      = conv_req & ~req_d_r;
        req_d_nxt = rst_b & conv_req;
        spd_nxt   = speed_tick ? 32'h0 : spd_r + 32'h1;
        rly_nxt   = relay_tick ? 32'h0 : rly_r + 32'h1;
        trg_nxt   = (rise && conv_chan == 4'h0) ? 32'h0 : trg_r + 32'h1;
        seen_nxt  = seen_r | {rise && conv_chan == 4'h0, relay_tick,
                              speed_tick};
        last_nxt  = rise ? conv_chan : last_r;
        // reset forgets history
        if (!rst_b)
        begin
            seen_nxt = 3'h0;
            last_nxt = 4'h6;
        end
    end

    // register only
    always_ff @(posedge core_clk)
    begin
        spd_r   <= spd_nxt;
        rly_r   <= rly_nxt;
        trg_r   <= trg_nxt;
        seen_r  <= seen_nxt;
        last_r  <= last_nxt;
        req_d_r <= req_d_nxt;
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    property p_speed_period;
        seen_r[0] |-> speed_tick == (spd_r == SPEED_CYC - 1);
    endproperty
    a_speed_period: assert property (p_speed_period)
        else $error("speed tick period wrong");
    property p_relay_period;
        seen_r[1] |-> relay_tick == (rly_r == RELAY_CYC - 1);
    endproperty
    a_relay_period: assert property (p_relay_period)
        else $error("relay tick period wrong");
    property p_req_gate;
        conv_req |-> scan_ready && !cal_req;
    endproperty
    a_req_gate: assert property (p_req_gate)
        else $error("request before calibration end");
    property p_cal_answer;
        $rose(cal_done_in) && cal_req |-> ##[2:5] (scan_ready && !cal_req);
    endproperty
    a_cal_answer: assert property (p_cal_answer)
        else $error("calibration end not answered");
    property p_timeout_cause;
        $rose(cal_timeout) |-> cal_req && !scan_ready;
    endproperty
    a_timeout_cause: assert property (p_timeout_cause)
        else $error("timeout without pending calibration");
    property p_chan_order;
        $rose(conv_req) |-> conv_chan ==
            ((last_r == 4'h6) ? 4'h0 : last_r + 4'h2);
    endproperty
    a_chan_order: assert property (p_chan_order)
        else $error("channel order wrong");
    property p_req_hold;
        $rose(conv_req) |=> (conv_req && $stable(conv_chan)) [*3];
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("request not held");
    property p_trough_spacing;
        $rose(conv_req) && conv_chan == 4'h0 && seen_r[2] |->
            trg_r % (2 * CARRIER_HALF) == 2 * CARRIER_HALF - 1;
    endproperty
    a_trough_spacing: assert property (p_trough_spacing)
        else $error("scan start off the trough");
    property p_scan_end;
        scan_done |-> last_r == 4'h6 ##1 !scan_done;
    endproperty
    a_scan_end: assert property (p_scan_end)
        else $error("scan end early or long");
endmodule // mtat_monitor

bind mtat_top mtat_monitor #(
    .SPEED_CYC   (SPEED_CYC),
    .RELAY_CYC   (RELAY_CYC),
    .CARRIER_HALF(CARRIER_HALF)
) u_monitor (.*);

// ===== tb/mtat_adc_model.sv
// converter stand-in: calibrates, answers four-phase requests
// assumes mtat_top drives cal_req, conv_req and conv_chan
`include "mtat_map.svh"
module mtat_adc_model (
    input  wire logic                  core_clk,
    input  wire logic                  rst_b,
    input  wire logic                  cal_req,
    input  wire logic                  conv_req,
    input  wire logic [`MTAT_CH_W-1:0] conv_chan,
    input  wire logic [15:0]           cal_wait,
    input  wire logic [15:0]           conv_wait,
    input  wire logic [7:0]            base,
    output logic                       cal_done_in,
    output logic                       conv_done_in,
    output logic [`MTAT_RES_W-1:0]     conv_data_in
);
    timeunit 1ns;
    timeprecision 100ps;

    int cal_cnt = 0;  // cycles spent calibrating
    int wait_cnt = 0; // cycles since request seen

    initial
    begin
        cal_done_in = 1'b0;
        conv_done_in = 1'b0;
        conv_data_in = 12'h000;
    end

    // answer just after each edge, like real logic
    always @(posedge core_clk)
    begin
        #1;
        if (!rst_b)
        begin
            cal_done_in = 1'b0;
            conv_done_in = 1'b0;
            cal_cnt = 0;
            wait_cnt = 0;
        end
        else
        begin
            // calibration lasts cal_wait cycles, then stays done
            if (cal_req && !cal_done_in)
                cal_cnt++;
            if (cal_cnt >= cal_wait)
                cal_done_in = 1'b1;
            if (conv_req && !conv_done_in && ++wait_cnt >= conv_wait)
            begin
                conv_done_in = 1'b1;
                // uncalibrated results come out wrong
                conv_data_in = cal_done_in ? {base, conv_chan}
                                           : ~{base, conv_chan};
            end
            else if (!conv_req && conv_done_in)
            begin
                conv_done_in = 1'b0;
                wait_cnt = 0;
                // released data must not look valid
                conv_data_in = ~conv_data_in;
            end
        end
    end
endmodule // mtat_adc_model

// ===== tb/mtat_top_tb.sv
// self-checking bench for mtat_top with a converter stand-in
// assumes shortened counts: ticks 50/100, half carrier 40, cal 200
`include "mtat_map.svh"
module mtat_top_tb;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int SPD  = 50;
    localparam int RLY  = 100;
    localparam int HALF = 40;
    localparam int CAL  = 200;

    logic        core_clk  = 1'b0;
    logic        rst_b     = 1'b0;
    logic [15:0] cal_wait  = 16'h012c; // past the timeout limit
    logic [15:0] conv_wait = 16'h0002; // fast converter
    logic [7:0]  base      = 8'h00;    // result pattern
    logic        cal_done_in, conv_done_in, speed_tick, relay_tick;
    logic        cal_req, cal_timeout, scan_ready, conv_req;
    logic        scan_done, trig_missed;
    logic [3:0]  conv_chan;
    logic [11:0] conv_data_in, bus_volt, cur_u, cur_v, cur_w;
    int          err_total = 0;
    int          samples_checked = 0;

    always #2.5 core_clk = ~core_clk;

    mtat_top #(.SPEED_CYC(SPD), .RELAY_CYC(RLY), .CARRIER_HALF(HALF),
               .CAL_CYC(CAL)) DUT (.*);
    mtat_adc_model u_adc (.*);

    // compare and count
    task automatic chk_val(string nm, logic [31:0] exp, logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wrap_up;
        $display("compares %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // advance and settle past the edge
    task automatic tick(int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // bounded wait on a flag; a hang ends the run
    task automatic wait_flag(string nm, ref logic f, input int lim);
        int i;
        for (i = 0; i < lim && f !== 1'b1; i++)
            tick(1);
        if (i == lim)
        begin
            err_total++;
            $display("ERROR %s expected 1 seen timeout", nm);
            wrap_up();
        end
    endtask

    task automatic do_reset;
        rst_b = 1'b0;
        tick(20);
        chk_val("ready in reset", 1'h0, scan_ready);
        chk_val("request in reset", 1'h0, conv_req);
        chk_val("bus volt in reset", 12'h000, bus_volt);
        rst_b = 1'b1;
    endtask

    // slow calibration: no requests, timeout flag, then ready
    task automatic t_cal_slow;
        int n;
        n = 0;
        do_reset();
        repeat (250)
        begin
            n += (conv_req !== 1'b0);
            tick(1);
        end
        chk_val("early requests", 0, n);
        chk_val("cal timeout", 1'h1, cal_timeout);
        chk_val("ready early", 1'h0, scan_ready);
        wait_flag("scan ready", scan_ready, 100);
        chk_val("cal request", 1'h0, cal_req);
    endtask

    // any 1000-cycle window holds a fixed tick count
    task automatic t_ticks;
        int s, r;
        s = 0;
        r = 0;
        repeat (1000)
        begin
            s += (speed_tick === 1'b1);
            r += (relay_tick === 1'b1);
            tick(1);
        end
        chk_val("speed ticks", 1000 / SPD, s);
        chk_val("relay ticks", 1000 / RLY, r);
    endtask

    // pattern changes between scans, so a stale result shows
    task automatic t_scan(logic [7:0] b);
        wait_flag("scan done", scan_done, 400);
        base = b;
        tick(1);
        wait_flag("next scan done", scan_done, 400);
        chk_val("cur w", {b, 4'h0}, cur_w);
        chk_val("cur v", {b, 4'h2}, cur_v);
        chk_val("cur u", {b, 4'h4}, cur_u);
        chk_val("bus volt", {b, 4'h6}, bus_volt);
        tick(1);
    endtask

    // slow converter overruns a carrier period
    task automatic t_missed;
        conv_wait = 16'h0014;
        wait_flag("dropped trough", trig_missed, 400);
        t_scan(8'h96);
        conv_wait = 16'h0002;
    endtask

    // reset mid-scan, then quick calibration
    task automatic t_rereset;
        wait_flag("request", conv_req, 200);
        cal_wait = 16'h0005;
        do_reset();
        wait_flag("ready again", scan_ready, 50);
        chk_val("no timeout", 1'h0, cal_timeout);
        t_scan(8'h5a);
    endtask

    initial
    begin
        t_cal_slow();
        t_ticks();
        t_scan(8'h3c);
        t_scan(8'hc3);
        t_missed();
        t_rereset();
        wrap_up();
    end
endmodule // mtat_top_tb
